/* File: logic/asf_pkg.sv */
// shared constants and types for the converter flag and readout ends
`default_nettype none
package asf_pkg;

  // ==================================================================
  // widths
  localparam int NINST = 3;
  localparam int NPRE  = 4;
  localparam int DW    = 16;
  localparam int BW12  = 12;
  localparam int B8    = 8;
  localparam int NFLG  = 7;
  localparam int NIEN  = 4;

  // ==================================================================
  // flag positions inside one instance's status word
  localparam int FLG_RDY  = 0;
  localparam int FLG_OVF  = 1;
  localparam int FLG_OST  = 2;
  localparam int FLG_PST  = 3;
  localparam int FLG_PEND = 4;
  localparam int FLG_OEND = 5;
  localparam int FLG_MONITOR_OUT_OF_RANGE_FLAG = 6;

  // interrupt enable positions
  localparam int IEN_OVF  = 0;
  localparam int IEN_PEND = 1;
  localparam int IEN_OEND = 2;
  localparam int IEN_MONITOR_OUT_OF_RANGE_FLAG = 3;

  // ==================================================================
  // combined dma mode codes
  localparam logic [2:0] DMA_OFF = 3'h0;
  localparam logic [2:0] DMA_M1  = 3'h1;
  localparam logic [2:0] DMA_M2  = 3'h2;
  localparam logic [2:0] DMA_M3  = 3'h3;
  localparam logic [2:0] DMA_M4  = 3'h4;
  localparam logic [2:0] DMA_M5  = 3'h5;

  // ==================================================================
  // reset values
  localparam logic [NFLG-1:0] RST_FLAGS = 7'h00;
  localparam logic [DW-1:0]   RST_DATA  = 16'h0000;
  localparam logic [31:0]     RST_WORD  = 32'h0000_0000;

  typedef logic [NINST-1:0][DW-1:0] asf_res3_t;

  typedef enum logic [1:0] {
    ASF_RD_ORD  = 2'h0,
    ASF_RD_PRE  = 2'h1,
    ASF_RD_PACK = 2'h2
  } asf_rd_t;

  typedef enum logic [1:0] {
    ASF_H_IDLE = 2'h1,
    ASF_H_WAIT = 2'h2
  } asf_hst_t;

endpackage
`default_nettype wire

/* File: logic/asf_if.sv */
// link between the converter readout end and the dma or processor end
`timescale 1ns/10ps
`default_nettype none
interface asf_if;
  logic [2:0]                    dma_en;
  logic [2:0]                    drc_en;
  logic [2:0]                    each_en;
  logic                          comb_en;
  logic [2:0]                    mode;
  logic                          two_slaves;
  logic [2:0][3:0]               int_en;
  logic [2:0][15:0]              hi_b;
  logic [2:0][15:0]              lo_b;
  logic                          rd_en;
  asf_pkg::asf_rd_t              rd_sel;
  logic [1:0]                    rd_inst;
  logic [1:0]                    rd_ch;
  logic                          rd_dma;
  logic                          rvalid;
  logic [31:0]                   rdata;
  logic                          clr_en;
  logic [1:0]                    clr_inst;
  logic [6:0]                    clr_mask;
  logic [2:0]                    dma_req;
  logic [20:0]                   common_status;
  logic                          irq;

  modport dev (
    input  dma_en, drc_en, each_en, comb_en, mode, two_slaves, int_en,
    input  hi_b, lo_b, rd_en, rd_sel, rd_inst, rd_ch, rd_dma,
    input  clr_en, clr_inst, clr_mask,
    output rvalid, rdata, dma_req, common_status, irq
  );

  modport host (
    output dma_en, drc_en, each_en, comb_en, mode, two_slaves, int_en,
    output hi_b, lo_b, rd_en, rd_sel, rd_inst, rd_ch, rd_dma,
    output clr_en, clr_inst, clr_mask,
    input  rvalid, rdata, dma_req, common_status, irq
  );
endinterface
`default_nettype wire

/* File: logic/asf_dev.sv */
// converter end: status flags, interrupt merge and result readout
// Functional notes
// - ready flag follows power, read-only, no interrupt
// - overflow when unread result overwritten, detection gated
// - overflow cleared by software only, interrupt capable
// - non-combined overflow halts, sequence kept, retrigger resumes
// - combined overflow halts; controller resets every converter
// - start flags set on start, software clear only
// - preempted end flag set, software cleared, interrupts
// - ordinary end cleared by software or result read
// - dma result read clears ordinary end flag; here combined packed reads do not clear it
// - each-result mode sets end flag per update; set here only when not combined
// - monitor flag set on out-of-range result
// - three instance interrupts merged onto one output
// - common status mirror is read-only
// - preempted results never request dma
// - non-combined dma request on each result update
// - combined results packed, first instance requests dma
// - mode one: single zero-extended result, rotating
// - mode two: two 16-bit results per request
// - mode three: two bytes, upper half zero
// - modes four and five for two slaves
// - processor never reads ordinary results when combined
// - dma modes limited by resolution and slaves
// - out of range: above high or below low
`timescale 1ns/10ps
`default_nettype none
module asf_dev (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  asf_if.dev                        bus,
  input  wire logic [2:0]           powered,
  input  wire logic [2:0]           ord_start,
  input  wire logic [2:0]           pre_start,
  input  wire logic [2:0]           pre_end,
  input  wire logic [2:0]           ord_done,
  input  wire logic [2:0]           ord_seq_end,
  input  wire asf_pkg::asf_res3_t   ord_data,
  input  wire logic [2:0]           pre_wr,
  input  wire logic [1:0]           pre_wr_ch,
  input  wire logic [15:0]          pre_wr_data,
  input  wire logic [2:0]           mon_en,
  input  wire logic [2:0]           ovs_en,
  output logic [2:0]                halt
);

  // ==================================================================
  // helpers
  function automatic logic oor(input logic [15:0] d,
                               input logic [15:0] hi,
                               input logic [15:0] lo,
                               input logic        ovs);
    if (ovs)
      oor = (d > hi) || (d < lo);
    else
      oor = (d[asf_pkg::BW12-1:0] > hi[asf_pkg::BW12-1:0]) ||
            (d[asf_pkg::BW12-1:0] < lo[asf_pkg::BW12-1:0]);
  endfunction

  // {upper instance, lower instance} for the paired modes
  function automatic logic [3:0] pair(input logic two,
                                      input logic [1:0] step);
    if (!two)
      pair = {2'h1, 2'h0};
    else
      case (step)
        2'h0:    pair = {2'h1, 2'h0};
        2'h1:    pair = {2'h0, 2'h2};
        default: pair = {2'h2, 2'h1};
      endcase
  endfunction

  function automatic logic [2:0] need(input logic [2:0] mode,
                                      input logic two,
                                      input logic [1:0] step);
    logic [3:0] p;
    p = pair(two, step);
    case (mode)
      asf_pkg::DMA_M1: need = 3'h1 << step;
      asf_pkg::DMA_M2,
      asf_pkg::DMA_M3: need = (3'h1 << p[3:2]) | (3'h1 << p[1:0]);
      asf_pkg::DMA_M4: need = 3'h7;
      asf_pkg::DMA_M5: need = (step == 2'h0) ? 3'h3 : 3'h4;
      default:         need = 3'h0;
    endcase
  endfunction

  function automatic logic [1:0] last(input logic [2:0] mode,
                                      input logic two);
    case (mode)
      asf_pkg::DMA_M1: last = two ? 2'h2 : 2'h1;
      asf_pkg::DMA_M2,
      asf_pkg::DMA_M3: last = two ? 2'h2 : 2'h0;
      asf_pkg::DMA_M5: last = 2'h1;
      default:         last = 2'h0;
    endcase
  endfunction

  function automatic logic [31:0] word(input logic [2:0] mode,
                                       input logic two,
                                       input logic [1:0] step,
                                       input asf_pkg::asf_res3_t q);
    logic [3:0] p;
    p = pair(two, step);
    case (mode)
      asf_pkg::DMA_M1: word = {16'h0000, q[step]};
      asf_pkg::DMA_M2: word = {q[p[3:2]], q[p[1:0]]};
      asf_pkg::DMA_M3: word = {16'h0000, q[p[3:2]][asf_pkg::B8-1:0],
                               q[p[1:0]][asf_pkg::B8-1:0]};
      asf_pkg::DMA_M4: word = {8'h00, q[2][asf_pkg::B8-1:0],
                               q[1][asf_pkg::B8-1:0],
                               q[0][asf_pkg::B8-1:0]};
      asf_pkg::DMA_M5: word = (step == 2'h0) ? {q[1], q[0]}
                                             : {16'h0000, q[2]};
      default:         word = asf_pkg::RST_WORD;
    endcase
  endfunction

  // ==================================================================
  // state
  logic [2:0][6:0]              flags_ff;
  logic [2:0][6:0]              nxt_flags;
  logic [2:0]                   unread_ff;
  logic [2:0]                   nxt_unread;
  logic [2:0]                   req_ff;
  logic [2:0]                   req_set;
  logic [2:0]                   req_clr;
  logic [1:0]                   step_ff;
  logic [31:0]                  packed_ff;
  logic [31:0]                  rdata_ff;
  logic                         rvalid_ff;
  asf_pkg::asf_res3_t           ord_q_ff;
  logic [15:0]                  pre_q_ff [3][4];
  logic [2:0]                   pack_need;
  logic                         pack_on;
  logic                         pack_fire;
  logic [2:0]                   irq_vec;

  // ==================================================================
  // flag and request next values
  always_comb
  begin
    logic [6:0] set_v;
    logic [6:0] clr_v;
    logic       rd_hit;
    logic       det;
    set_v     = '0;
    clr_v     = '0;
    rd_hit    = 1'b0;
    det       = 1'b0;
    pack_on   = bus.comb_en && (bus.mode != asf_pkg::DMA_OFF);
    pack_need = need(bus.mode, bus.two_slaves, step_ff);
    // a packed word waits while the previous one is still unread
    pack_fire = pack_on && !req_ff[0] && (pack_need != 3'h0) &&
                ((unread_ff & pack_need) == pack_need);
    for (int i = 0; i < asf_pkg::NINST; i++)
    begin
      rd_hit = bus.rd_en && (bus.rd_sel == asf_pkg::ASF_RD_ORD) &&
               (bus.rd_inst == 2'(i));
      nxt_unread[i] = ord_done[i] ||
                      (unread_ff[i] && !rd_hit &&
                       !(pack_fire && pack_need[i]));
      det = bus.dma_en[i] || bus.each_en[i] || pack_on;
      set_v = '0;
      set_v[asf_pkg::FLG_OVF]  = ord_done[i] && unread_ff[i] && det &&
                                 !rd_hit;
      set_v[asf_pkg::FLG_OST]  = ord_start[i];
      set_v[asf_pkg::FLG_PST]  = pre_start[i];
      set_v[asf_pkg::FLG_PEND] = pre_end[i];
      set_v[asf_pkg::FLG_OEND] = ord_seq_end[i] ||
                                 (ord_done[i] && bus.each_en[i] &&
                                  !bus.comb_en);
      set_v[asf_pkg::FLG_MONITOR_OUT_OF_RANGE_FLAG] = mon_en[i] &&
        ((ord_done[i] && oor(ord_data[i], bus.hi_b[i], bus.lo_b[i],
                             ovs_en[i])) ||
         (pre_wr[i] && oor(pre_wr_data, bus.hi_b[i], bus.lo_b[i],
                           ovs_en[i])));
      clr_v = (bus.clr_en && (bus.clr_inst == 2'(i))) ? bus.clr_mask
                                                     : 7'h00;
      // cpu or dma result read also drops the end flag
      clr_v[asf_pkg::FLG_OEND] = clr_v[asf_pkg::FLG_OEND] ||
                                 rd_hit;
      // set wins over a clear in the same cycle
      nxt_flags[i] = (flags_ff[i] & ~clr_v) | set_v;
      nxt_flags[i][asf_pkg::FLG_RDY] = powered[i];
      req_set[i] = ord_done[i] && bus.dma_en[i] && bus.drc_en[i] &&
                   !bus.comb_en;
      req_clr[i] = bus.rd_en && bus.rd_dma && rd_hit;
    end
    req_set[0] = req_set[0] || pack_fire;
    req_clr[0] = req_clr[0] || (bus.rd_en && bus.rd_dma &&
                                (bus.rd_sel == asf_pkg::ASF_RD_PACK));
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flags_ff  <= {3{asf_pkg::RST_FLAGS}};
      unread_ff <= 3'h0;
    end
    else
    begin
      flags_ff  <= nxt_flags;
      unread_ff <= nxt_unread;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      req_ff <= 3'h0;
    else
      req_ff <= req_set | (req_ff & ~req_clr);
  end

  // ==================================================================
  // combined packing
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      step_ff   <= 2'h0;
      packed_ff <= asf_pkg::RST_WORD;
    end
    else if (!pack_on)
      step_ff <= 2'h0;
    else if (pack_fire)
    begin
      packed_ff <= word(bus.mode, bus.two_slaves, step_ff, ord_q_ff);
      step_ff   <= (step_ff == last(bus.mode, bus.two_slaves)) ?
                   2'h0 : step_ff + 2'h1;
    end
  end

  // ==================================================================
  // result storage; preempted results have no dma path
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      ord_q_ff <= {3{asf_pkg::RST_DATA}};
    else
      for (int i = 0; i < asf_pkg::NINST; i++)
        if (ord_done[i])
          ord_q_ff[i] <= ord_data[i];
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int i = 0; i < asf_pkg::NINST; i++)
        for (int c = 0; c < asf_pkg::NPRE; c++)
          pre_q_ff[i][c] <= asf_pkg::RST_DATA;
    end
    else
      for (int i = 0; i < asf_pkg::NINST; i++)
        if (pre_wr[i])
          pre_q_ff[i][pre_wr_ch] <= pre_wr_data;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_ff  <= asf_pkg::RST_WORD;
      rvalid_ff <= 1'b0;
    end
    else
    begin
      rvalid_ff <= bus.rd_en;
      if (bus.rd_en)
      begin
        if (bus.rd_inst == 2'h3)
          rdata_ff <= asf_pkg::RST_WORD;
        else
          case (bus.rd_sel)
            asf_pkg::ASF_RD_ORD:
              rdata_ff <= {16'h0000, ord_q_ff[bus.rd_inst]};
            asf_pkg::ASF_RD_PRE:
              rdata_ff <= {16'h0000, pre_q_ff[bus.rd_inst][bus.rd_ch]};
            asf_pkg::ASF_RD_PACK:
              rdata_ff <= packed_ff;
            default:
              rdata_ff <= asf_pkg::RST_WORD;
          endcase
      end
    end
  end

  // ==================================================================
  // outputs
  always_comb
  begin
    for (int i = 0; i < asf_pkg::NINST; i++)
      irq_vec[i] = |(bus.int_en[i] &
                     {flags_ff[i][asf_pkg::FLG_MONITOR_OUT_OF_RANGE_FLAG],
                      flags_ff[i][asf_pkg::FLG_OEND],
                      flags_ff[i][asf_pkg::FLG_PEND],
                      flags_ff[i][asf_pkg::FLG_OVF]});
  end

  assign bus.irq           = |irq_vec;
  // no write path exists into the mirror
  assign bus.common_status = {flags_ff[2], flags_ff[1],
                              flags_ff[0]};
  assign bus.dma_req       = req_ff;
  assign bus.rdata         = rdata_ff;
  assign bus.rvalid        = rvalid_ff;

  // the converter stays stopped until overflow is cleared; in combined
  // mode the far side must also reset each converter
  always_comb
  begin
    for (int i = 0; i < asf_pkg::NINST; i++)
      halt[i] = flags_ff[i][asf_pkg::FLG_OVF];
  end

endmodule
`default_nettype wire

/* File: logic/asf_host.sv */
// dma and processor end: config, result reads and flag clears
`timescale 1ns/10ps
`default_nettype none
module asf_host (
  input  wire logic                 core_clk,
  input  wire logic                 arst_n,
  asf_if.host                       bus,
  input  wire logic [2:0]           cfg_dma_en,
  input  wire logic [2:0]           cfg_drc_en,
  input  wire logic [2:0]           cfg_each_en,
  input  wire logic                 cfg_comb_en,
  input  wire logic [2:0]           cfg_mode,
  input  wire logic                 cfg_two_slaves,
  input  wire logic                 cfg_low_res,
  input  wire logic                 cfg_shift,
  input  wire logic [2:0][3:0]      cfg_int_en,
  input  wire logic [2:0][15:0]     cfg_hi_b,
  input  wire logic [2:0][15:0]     cfg_lo_b,
  input  wire logic [2:0]           dma_chan_en,
  input  wire logic                 cpu_rd,
  input  wire asf_pkg::asf_rd_t     cpu_sel,
  input  wire logic [1:0]           cpu_inst,
  input  wire logic [1:0]           cpu_ch,
  output logic                      cpu_busy,
  output logic                      cpu_rvalid,
  output logic                      cpu_err,
  output logic [31:0]               cpu_rdata,
  output logic                      dma_valid,
  output logic [1:0]                dma_inst,
  output logic [31:0]               dma_data,
  input  wire logic                 clr_req,
  input  wire logic [1:0]           clr_inst,
  input  wire logic [6:0]           clr_mask,
  output logic [20:0]               status,
  output logic                      irq
);

  // illegal mode and resolution pairings fall back to no dma
  function automatic logic [2:0] legal(input logic [2:0] m,
                                       input logic two,
                                       input logic low,
                                       input logic sh);
    logic ok;
    case (m)
      asf_pkg::DMA_M1: ok = 1'b1;
      asf_pkg::DMA_M2: ok = !two || sh;
      asf_pkg::DMA_M3: ok = low && (!two || sh);
      asf_pkg::DMA_M4: ok = low && two;
      asf_pkg::DMA_M5: ok = two;
      default:         ok = 1'b0;
    endcase
    legal = ok ? m : asf_pkg::DMA_OFF;
  endfunction

  asf_pkg::asf_hst_t            state_ff;
  logic                         rd_en_ff;
  asf_pkg::asf_rd_t             rd_sel_ff;
  logic [1:0]                   rd_inst_ff;
  logic [1:0]                   rd_ch_ff;
  logic                         own_dma_ff;
  logic                         clr_en_ff;
  logic [1:0]                   clr_inst_ff;
  logic [6:0]                   clr_mask_ff;
  logic                         pick;
  logic [1:0]                   pick_inst;
  logic                         cpu_take;
  logic                         cpu_bad;

  // ==================================================================
  // arbitration: dma first, lowest instance first
  always_comb
  begin
    pick      = 1'b0;
    pick_inst = 2'h0;
    if (bus.comb_en)
      pick = bus.dma_req[0] && dma_chan_en[0];
    else
      for (int i = asf_pkg::NINST - 1; i >= 0; i--)
        if (bus.dma_req[i] && dma_chan_en[i])
        begin
          pick      = 1'b1;
          pick_inst = 2'(i);
        end
  end

  assign cpu_busy = (state_ff != asf_pkg::ASF_H_IDLE) || pick;
  assign cpu_take = cpu_rd && !cpu_busy;
  assign cpu_bad  = cpu_take && bus.comb_en &&
                    (cpu_sel == asf_pkg::ASF_RD_ORD);

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_ff   <= asf_pkg::ASF_H_IDLE;
      rd_en_ff   <= 1'b0;
      rd_sel_ff  <= asf_pkg::ASF_RD_ORD;
      rd_inst_ff <= 2'h0;
      rd_ch_ff   <= 2'h0;
      own_dma_ff <= 1'b0;
    end
    else
    begin
      rd_en_ff <= 1'b0;
      case (state_ff)
        asf_pkg::ASF_H_IDLE:
          if (pick)
          begin
            rd_en_ff   <= 1'b1;
            rd_sel_ff  <= bus.comb_en ? asf_pkg::ASF_RD_PACK
                                      : asf_pkg::ASF_RD_ORD;
            rd_inst_ff <= pick_inst;
            rd_ch_ff   <= 2'h0;
            own_dma_ff <= 1'b1;
            state_ff   <= asf_pkg::ASF_H_WAIT;
          end
          else if (cpu_take && !cpu_bad)
          begin
            rd_en_ff   <= 1'b1;
            rd_sel_ff  <= cpu_sel;
            rd_inst_ff <= cpu_inst;
            rd_ch_ff   <= cpu_ch;
            own_dma_ff <= 1'b0;
            state_ff   <= asf_pkg::ASF_H_WAIT;
          end
        asf_pkg::ASF_H_WAIT:
          if (bus.rvalid)
            state_ff <= asf_pkg::ASF_H_IDLE;
        default:
          state_ff <= asf_pkg::ASF_H_IDLE;
      endcase
    end
  end

  // ==================================================================
  // returned data
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpu_rvalid <= 1'b0;
      cpu_err    <= 1'b0;
      cpu_rdata  <= asf_pkg::RST_WORD;
      dma_valid  <= 1'b0;
      dma_inst   <= 2'h0;
      dma_data   <= asf_pkg::RST_WORD;
    end
    else
    begin
      cpu_err    <= cpu_bad;
      cpu_rvalid <= bus.rvalid && !own_dma_ff;
      dma_valid  <= bus.rvalid && own_dma_ff;
      if (bus.rvalid && !own_dma_ff)
        cpu_rdata <= bus.rdata;
      if (bus.rvalid && own_dma_ff)
      begin
        dma_data <= bus.rdata;
        dma_inst <= rd_inst_ff;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      clr_en_ff   <= 1'b0;
      clr_inst_ff <= 2'h0;
      clr_mask_ff <= asf_pkg::RST_FLAGS;
    end
    else
    begin
      clr_en_ff   <= clr_req;
      clr_inst_ff <= clr_inst;
      clr_mask_ff <= clr_mask;
    end
  end

  // ==================================================================
  // link drive
  assign bus.dma_en     = cfg_dma_en;
  assign bus.drc_en     = cfg_drc_en;
  assign bus.each_en    = cfg_each_en;
  assign bus.comb_en    = cfg_comb_en;
  assign bus.mode       = legal(cfg_mode, cfg_two_slaves, cfg_low_res,
                                cfg_shift);
  assign bus.two_slaves = cfg_two_slaves;
  assign bus.int_en     = cfg_int_en;
  assign bus.hi_b       = cfg_hi_b;
  assign bus.lo_b       = cfg_lo_b;
  assign bus.rd_en      = rd_en_ff;
  assign bus.rd_sel     = rd_sel_ff;
  assign bus.rd_inst    = rd_inst_ff;
  assign bus.rd_ch      = rd_ch_ff;
  assign bus.rd_dma     = own_dma_ff;
  assign bus.clr_en     = clr_en_ff;
  assign bus.clr_inst   = clr_inst_ff;
  assign bus.clr_mask   = clr_mask_ff;
  assign status         = bus.common_status;
  assign irq            = bus.irq;

endmodule
`default_nettype wire

/* File: test/asf_asserts.sv */
// checker watching the link between the two ends
`timescale 1ns/10ps
`default_nettype none
module asf_asserts (
  input wire logic             core_clk,
  input wire logic             arst_n,
  input wire logic             rd_en,
  input wire asf_pkg::asf_rd_t rd_sel,
  input wire logic [1:0]       rd_inst,
  input wire logic             rd_dma,
  input wire logic             rvalid,
  input wire logic             clr_en,
  input wire logic [1:0]       clr_inst,
  input wire logic [6:0]       clr_mask,
  input wire logic [2:0]       dma_req,
  input wire logic [20:0]      common_status,
  input wire logic [2:0][3:0]  int_en,
  input wire logic             irq
);
  // ====================================================================
  // properties, flag and request ones on instance zero only to keep it short; irq check covers all three
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire logic       rd0 = rd_en && rd_inst == 2'h0;
  wire logic [6:0] k0 = (clr_en && clr_inst == 2'h0) ? clr_mask : 7'h00;
  logic            irq_x;
  always_comb
  begin
    irq_x = 1'b0;
    for (int j = 0; j < 3; j++)
      irq_x |= |({common_status[j*7+6], common_status[j*7+5 -: 2],
                  common_status[j*7+1]} & int_en[j]);
  end
  property p_rv; rvalid == $past(rd_en); endproperty
  property p_oe; rd0 && rd_sel == asf_pkg::ASF_RD_ORD |=>
    !common_status[5]; endproperty
  property p_dq; rd0 && rd_dma |=> !dma_req[0]; endproperty
  property p_irq; irq == irq_x; endproperty
  property p_ov; common_status[1] && !k0[1] |=> common_status[1]; endproperty
  property p_st; common_status[2] && !k0[2] |=> common_status[2]; endproperty
  property p_vm; common_status[6] && !k0[6] |=> common_status[6]; endproperty
  property p_rq; dma_req[0] && !(rd_en && rd_dma) |=> dma_req[0]; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  a_oe: assert property (p_oe) else $error("end flag kept");
  a_dq: assert property (p_dq) else $error("request kept");
  a_irq: assert property (p_irq) else $error("irq mismatch");
  a_ov: assert property (p_ov) else $error("overflow lost");
  a_st: assert property (p_st) else $error("start flag lost");
  a_vm: assert property (p_vm) else $error("monitor flag lost");
  a_rq: assert property (p_rq) else $error("request dropped");
  c_rd: cover property (rd_en && rd_dma);
  c_irq: cover property ($rose(irq));
  c_ov: cover property ($rose(common_status[1]));
endmodule
`default_nettype wire

/* File: test/tb_adc_status_flags_and_data_readout.sv */
// self-checking bench joining both ends across the link
`timescale 1ns/10ps
`default_nettype none
module tb_adc_status_flags_and_data_readout;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] powered, ord_start, pre_start, pre_end, ord_done, ord_seq_end;
  logic [2:0] pre_wr, mon_en, ovs_en, halt, cfg_dma_en, cfg_drc_en;
  logic [2:0] cfg_each_en, cfg_mode, dma_chan_en;
  logic cfg_comb_en, cfg_two_slaves, cfg_low_res, cfg_shift, cpu_rd;
  logic cpu_busy, cpu_rvalid, cpu_err, dma_valid, clr_req, irq;
  logic [1:0] pre_wr_ch, cpu_inst, cpu_ch, dma_inst, clr_inst;
  logic [15:0] pre_wr_data;
  logic [2:0][3:0] cfg_int_en;
  logic [2:0][15:0] cfg_hi_b, cfg_lo_b;
  logic [31:0] cpu_rdata, dma_data;
  logic [6:0] clr_mask;
  logic [20:0] status;
  asf_pkg::asf_res3_t ord_data;
  asf_pkg::asf_rd_t cpu_sel;
  int n_mismatch = 0, n_tests = 0, cyc = 0, i;
  asf_if bus ();
  asf_dev asf_dev_i (.*);
  asf_host asf_host_i (.*);
  asf_asserts asf_asserts_i (.core_clk, .arst_n, .rd_en(bus.rd_en),
    .rd_sel(bus.rd_sel), .rd_inst(bus.rd_inst), .rd_dma(bus.rd_dma),
    .rvalid(bus.rvalid), .clr_en(bus.clr_en), .clr_inst(bus.clr_inst),
    .clr_mask(bus.clr_mask), .dma_req(bus.dma_req), .irq(bus.irq),
    .common_status(bus.common_status), .int_en(bus.int_en));
  // ====================================================================
  // helpers
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task gen(input logic [2:0] m, input logic [15:0] v);
    ord_data = {v, ~v, v};
    ord_done = m;
    tick(1);
    ord_done = 3'h0;
    tick(1);
  endtask
  task cpu_ord(input logic [31:0] exp);
    cpu_rd = 1'b1;
    tick(1);
    cpu_rd = 1'b0;
    for (i = 0; i < 9 && !cpu_rvalid; i++) tick(1);
    chk(cpu_rdata, exp);
  endtask
  task dma_chk(input logic [31:0] exp);
    for (i = 0; i < 9 && !dma_valid; i++) tick(1);
    chk(dma_data, exp);
  endtask
  // ====================================================================
  // scenarios
  task t_each;
    gen(3'h1, 16'h0abc);
    chk({status[14], status[7], status[0]}, 3'h7);
    chk({irq, status[6:5]}, 3'h7);
    cpu_ord(32'h0000_0abc);
    chk({irq, status[5]}, 2'h0);
    $display("t_each done");
  endtask
  task t_ovf;
    gen(3'h1, 16'h0123);
    gen(3'h1, 16'h0456);
    chk({halt[0], status[1]}, 2'h3);
    {ord_start, pre_start, pre_end} = 9'h049;
    tick(1);
    {ord_start, pre_start, pre_end} = '0;
    chk(status[4:2], 3'h7);
    cpu_ord(32'h0000_0456);
    clr_mask = 7'h3f;
    clr_req = 1'b1;
    tick(1);
    clr_req = 1'b0;
    tick(3);
    chk({halt[0], status[6:0]}, 8'h41);
    $display("t_ovf done");
  endtask
  task t_dma;
    cfg_each_en = 3'h0;
    {cfg_dma_en, cfg_drc_en, dma_chan_en} = {3{3'h1}};
    pre_wr = 3'h1;
    tick(1);
    pre_wr = 3'h0;
    tick(2);
    chk(bus.dma_req, 3'h0);
    gen(3'h1, 16'h0234);
    dma_chk(32'h0000_0234);
    chk(status[1], 1'b0);
    $display("t_dma done");
  endtask
  task t_pack;
    {cfg_dma_en, cfg_drc_en} = 6'h00;
    cfg_comb_en = 1'b1;
    cfg_mode = asf_pkg::DMA_M2;
    tick(1);
    gen(3'h3, 16'h0111);
    dma_chk(32'hfeee_0111);
    gen(3'h3, 16'h0222);
    dma_chk(32'hfddd_0222);
    cpu_rd = 1'b1;
    tick(1);
    cpu_rd = 1'b0;
    chk(cpu_err, 1'b1);
    $display("t_pack done");
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {ord_start, pre_start, pre_end, ord_done, ord_seq_end, pre_wr} = '0;
    {ovs_en, cfg_dma_en, cfg_drc_en, cfg_mode, dma_chan_en, cpu_rd} = '0;
    {cfg_comb_en, cfg_two_slaves, cfg_low_res, cfg_shift, clr_req} = '0;
    {pre_wr_ch, cpu_inst, cpu_ch, clr_inst, pre_wr_data, clr_mask} = '0;
    {ord_data, cfg_lo_b} = '0;
    cpu_sel = asf_pkg::ASF_RD_ORD;
    powered = 3'h7;
    mon_en = 3'h1;
    cfg_each_en = 3'h1;
    cfg_int_en = 12'h004;
    cfg_hi_b = {3{16'h0800}};
    tick(10);
    arst_n = 1'b1;
    tick(2);
    t_each;
    t_ovf;
    t_dma;
    t_pack;
    report_and_stop;
  end
endmodule
`default_nettype wire
